// *** inc/sos_consts.vh ***
// constants for the status output selector: register offsets, reset codes, function codes
// assumes inclusion by bare name from design files; no processes here
`ifndef SOS_CONSTS_VH
`define SOS_CONSTS_VH

// ****************************************
// register map (byte addresses, one word each)
// ****************************************
`define SOS_OFS_FIRST_SEL 5'h00
`define SOS_OFS_RELAY_SEL 5'h04
`define SOS_OFS_SECOND_SEL 5'h08
`define SOS_OFS_FLAGS_IN 5'h0C
`define SOS_OFS_PINS 5'h10

// ****************************************
// reset codes
// ****************************************
`define SOS_RST_FIRST 16'h0000
`define SOS_RST_RELAY 16'h0063
`define SOS_RST_SECOND 16'h0050

// ****************************************
// codes and logic ranges
// ****************************************
`define SOS_NEG_OFFSET 16'h0064
`define SOS_NEG_LIMIT 16'h00C8
`define SOS_NO_FUNC 16'h270F
`define SOS_CODE_RUN 7'h00
`define SOS_CODE_AT_FREQ 7'h01
`define SOS_CODE_STALL 7'h03
`define SOS_CODE_FREQ_DET 7'h04
`define SOS_CODE_BRAKE_PRE 7'h07
`define SOS_CODE_THERM_PRE 7'h08
`define SOS_CODE_READY 7'h0B
`define SOS_CODE_CUR_DET 7'h0C
`define SOS_CODE_LOW_POWER 7'h0D
`define SOS_CODE_FB_LOW 7'h0E
`define SOS_CODE_FB_HIGH 7'h0F
`define SOS_CODE_LOOP_FWD 7'h10
`define SOS_CODE_FAN 7'h19
`define SOS_CODE_SINK_PRE 7'h1A
`define SOS_CODE_PWR_LOSS 7'h2E
`define SOS_CODE_PID 7'h2F
`define SOS_CODE_RETRY 7'h40
`define SOS_CODE_SLEEP 7'h46
`define SOS_CODE_SAFE 7'h50
`define SOS_CODE_SAFE2 7'h51
`define SOS_CODE_LIFE 7'h5A
`define SOS_CODE_PWROFF 7'h5B
`define SOS_CODE_AVG 7'h5D
`define SOS_CODE_MAINT 7'h5F
`define SOS_CODE_REMOTE 7'h60
`define SOS_CODE_ALARM 7'h62
`define SOS_CODE_FAULT 7'h63

`endif

// *** core/sos_status_output_selector.v ***
// status output selector: three terminal selection codes, status mux, Avalon-MM slave
// assumes status flags are synchronous to clock and already computed by the drive core
// assumes one bus master; a refused code write still completes with an OK response
//
// The Avalon-MM register port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "sos_consts.vh"

module sos_status_output_selector #(
  parameter FLAG_W = 26
) (
  input wire clock,
  input wire rst,
  // avalon-mm slave
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  output reg [1:0] avs_response,
  // status conditions from the drive core
  input wire running_flag,
  input wire frequency_reached_flag,
  input wire stall_active_flag,
  input wire freq_threshold_flag,
  input wire braking_duty_prealarm,
  input wire thermal_prealarm,
  input wire drive_ready_flag,
  input wire current_detect_flag,
  input wire low_power_detect,
  input wire loop_feedback_low,
  input wire loop_feedback_high,
  input wire loop_forward_flag,
  input wire fan_fault_flag,
  input wire heatsink_hot_prealarm,
  input wire power_loss_decel_flag,
  input wire power_loss_release,
  input wire loop_active_flag,
  input wire retry_active_flag,
  input wire loop_sleep_flag,
  input wire safety_stop_flag,
  input wire safety_ok_flag,
  input wire life_alarm_flag,
  input wire power_off_fault_flag,
  input wire current_avg_pulse,
  input wire maint_timer_flag,
  input wire remote_out_flag,
  input wire minor_alarm_flag,
  input wire fault_flag,
  // terminal drive, high = conducting
  output reg first_transistor_out,
  output reg relay_out,
  output reg second_transistor_out
);

  // ****************************************
  // selection registers
  // ****************************************
  reg [15:0] first_transistor_output_select;
  reg [15:0] relay_output_select;
  reg [15:0] second_transistor_output_select;
  reg power_loss_latched;

  // ****************************************
  // code decode functions
  // ****************************************
  // terminal indices for the per-terminal legality check
  localparam [1:0] TERMINAL_FIRST = 2'h0;
  localparam [1:0] TERMINAL_RELAY = 2'h1;
  localparam [1:0] TERMINAL_SECOND = 2'h2;

  // strips the negative-logic offset to get the function number
  function [6:0] sos_func;
    input [15:0] code;
    reg [15:0] base;
    begin
      if (code >= `SOS_NEG_OFFSET) begin
        base = code - `SOS_NEG_OFFSET;
      end else begin
        base = code;
      end
      sos_func = base[6:0]; // legal codes leave a function number below 100
    end
  endfunction

  // true when the function number is on the legal list
  function sos_listed;
    input [6:0] f;
    begin
      case (f)
        `SOS_CODE_RUN,
        `SOS_CODE_AT_FREQ,
        `SOS_CODE_STALL,
        `SOS_CODE_FREQ_DET,
        `SOS_CODE_BRAKE_PRE,
        `SOS_CODE_THERM_PRE,
        `SOS_CODE_READY,
        `SOS_CODE_CUR_DET,
        `SOS_CODE_LOW_POWER,
        `SOS_CODE_FB_LOW,
        `SOS_CODE_FB_HIGH,
        `SOS_CODE_LOOP_FWD,
        `SOS_CODE_FAN,
        `SOS_CODE_SINK_PRE,
        `SOS_CODE_PWR_LOSS,
        `SOS_CODE_PID,
        `SOS_CODE_RETRY,
        `SOS_CODE_SLEEP,
        `SOS_CODE_SAFE,
        `SOS_CODE_SAFE2,
        `SOS_CODE_LIFE,
        `SOS_CODE_PWROFF,
        `SOS_CODE_AVG,
        `SOS_CODE_MAINT,
        `SOS_CODE_REMOTE,
        `SOS_CODE_ALARM,
        `SOS_CODE_FAULT: sos_listed = 1'b1;
        default: sos_listed = 1'b0;
      endcase
    end
  endfunction

  // legality per terminal: 0 first, 1 relay, 2 second
  function sos_legal;
    input [15:0] code;
    input [1:0] term;
    begin
      if (code == `SOS_NO_FUNC) begin
        sos_legal = (term != TERMINAL_SECOND);
      end else if (code >= `SOS_NEG_LIMIT) begin
        sos_legal = 1'b0;
      end else if (term == TERMINAL_RELAY && sos_func(code) == `SOS_CODE_AVG) begin
        sos_legal = 1'b0;
      end else begin
        sos_legal = sos_listed(sos_func(code));
      end
    end
  endfunction

  // ****************************************
  // status vector
  // ****************************************
  // status vector indexed through the mux below
  wire [FLAG_W-1:0] status_vec;
  assign status_vec = {
    fault_flag, // bit 25
    minor_alarm_flag,
    remote_out_flag,
    maint_timer_flag,
    current_avg_pulse,
    power_off_fault_flag,
    life_alarm_flag,
    safety_ok_flag,
    safety_stop_flag,
    loop_sleep_flag,
    retry_active_flag,
    loop_active_flag,
    power_loss_latched,
    heatsink_hot_prealarm,
    fan_fault_flag,
    loop_forward_flag,
    loop_feedback_high,
    loop_feedback_low,
    low_power_detect,
    current_detect_flag,
    drive_ready_flag,
    thermal_prealarm,
    braking_duty_prealarm,
    freq_threshold_flag,
    stall_active_flag,
    frequency_reached_flag // bit 0
  };

  // selected function level for a code
  function sos_active;
    input [15:0] code;
    input [FLAG_W-1:0] sv;
    input run;
    begin
      case (sos_func(code))
        `SOS_CODE_RUN: sos_active = run;
        `SOS_CODE_AT_FREQ: sos_active = sv[0];
        `SOS_CODE_STALL: sos_active = sv[1];
        `SOS_CODE_FREQ_DET: sos_active = sv[2];
        `SOS_CODE_BRAKE_PRE: sos_active = sv[3];
        `SOS_CODE_THERM_PRE: sos_active = sv[4];
        `SOS_CODE_READY: sos_active = sv[5];
        `SOS_CODE_CUR_DET: sos_active = sv[6];
        `SOS_CODE_LOW_POWER: sos_active = sv[7];
        `SOS_CODE_FB_LOW: sos_active = sv[8];
        `SOS_CODE_FB_HIGH: sos_active = sv[9];
        `SOS_CODE_LOOP_FWD: sos_active = sv[10];
        `SOS_CODE_FAN: sos_active = sv[11];
        `SOS_CODE_SINK_PRE: sos_active = sv[12];
        `SOS_CODE_PWR_LOSS: sos_active = sv[13];
        `SOS_CODE_PID: sos_active = sv[14];
        `SOS_CODE_RETRY: sos_active = sv[15];
        `SOS_CODE_SLEEP: sos_active = sv[16];
        `SOS_CODE_SAFE: sos_active = sv[17];
        `SOS_CODE_SAFE2: sos_active = sv[18];
        `SOS_CODE_LIFE: sos_active = sv[19];
        `SOS_CODE_PWROFF: sos_active = sv[20];
        `SOS_CODE_AVG: sos_active = sv[21];
        `SOS_CODE_MAINT: sos_active = sv[22];
        `SOS_CODE_REMOTE: sos_active = sv[23];
        `SOS_CODE_ALARM: sos_active = sv[24];
        `SOS_CODE_FAULT: sos_active = sv[25];
        default: sos_active = 1'b0;
      endcase
    end
  endfunction

  // conducting level of a terminal from its code
  function sos_drive;
    input [15:0] code;
    input [FLAG_W-1:0] sv;
    input run;
    begin
      if (code == `SOS_NO_FUNC) begin
        sos_drive = 1'b0;
      end else if (code >= `SOS_NEG_OFFSET) begin
        sos_drive = ~sos_active(code, sv, run);
      end else begin
        sos_drive = sos_active(code, sv, run);
      end
    end
  endfunction

  // ****************************************
  // bus slave
  // ****************************************
  wire [15:0] wr_code;
  wire wr_full;
  wire bus_req;
  assign wr_code = avs_writedata[15:0];
  assign wr_full = avs_byteenable[1] & avs_byteenable[0];
  assign bus_req = (avs_read | avs_write) & avs_waitrequest;

  // ****************************************
  // address decode and write qualify
  // ****************************************
  // one hit line per mapped word; anything else is unmapped
  wire hit_first;
  wire hit_relay;
  wire hit_second;
  wire hit_flags;
  wire hit_pins;
  wire hit_any;
  assign hit_first = (avs_address == `SOS_OFS_FIRST_SEL);
  assign hit_relay = (avs_address == `SOS_OFS_RELAY_SEL);
  assign hit_second = (avs_address == `SOS_OFS_SECOND_SEL);
  assign hit_flags = (avs_address == `SOS_OFS_FLAGS_IN);
  assign hit_pins = (avs_address == `SOS_OFS_PINS);
  assign hit_any = hit_first | hit_relay | hit_second | hit_flags | hit_pins;

  // a code write lands only with both low byte lanes and a legal code
  wire wr_first;
  wire wr_relay;
  wire wr_second;
  assign wr_first = avs_write & hit_first & wr_full & sos_legal(wr_code, TERMINAL_FIRST);
  assign wr_relay = avs_write & hit_relay & wr_full & sos_legal(wr_code, TERMINAL_RELAY);
  assign wr_second = avs_write & hit_second & wr_full & sos_legal(wr_code, TERMINAL_SECOND);

  // ****************************************
  // read mux and bus answer
  // ****************************************
  // read mux; status and pin words are read only
  reg [31:0] next_readdata;
  always @* begin
    next_readdata = 32'h0000_0000;
    if (hit_first) begin
      next_readdata = {16'h0000, first_transistor_output_select};
    end else if (hit_relay) begin
      next_readdata = {16'h0000, relay_output_select};
    end else if (hit_second) begin
      next_readdata = {16'h0000, second_transistor_output_select};
    end else if (hit_flags) begin
      next_readdata = {{(32-FLAG_W-1){1'b0}}, status_vec, running_flag};
    end else if (hit_pins) begin
      next_readdata = {29'h0000_0000, second_transistor_out, relay_out, first_transistor_out};
    end
  end

  // one wait cycle, then answer; a refused write still completes
  always @(posedge clock) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      avs_response <= 2'b00;
      first_transistor_output_select <= `SOS_RST_FIRST;
      relay_output_select <= `SOS_RST_RELAY;
      second_transistor_output_select <= `SOS_RST_SECOND;
    end else if (bus_req) begin
      avs_waitrequest <= 1'b0;
      avs_readdata <= next_readdata;
      avs_response <= hit_any ? 2'b00 : 2'b10; // unmapped: slave error
      if (wr_first) begin
        first_transistor_output_select <= wr_code;
      end
      if (wr_relay) begin
        relay_output_select <= wr_code;
      end
      if (wr_second) begin
        second_transistor_output_select <= wr_code;
      end
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // ****************************************
  // power-loss latch and terminal drive
  // ****************************************
  // latch holds until release; a new event in the release cycle wins
  // the event is a level from the core, so a held event keeps it set
  always @(posedge clock) begin
    if (rst) begin
      power_loss_latched <= 1'b0;
    end else if (power_loss_decel_flag) begin
      power_loss_latched <= 1'b1;
    end else if (power_loss_release) begin
      power_loss_latched <= 1'b0;
    end
  end

  // next terminal levels, decoded combinationally from the current flags
  reg next_first_out;
  reg next_relay_out;
  reg next_second_out;
  always @* begin
    next_first_out = sos_drive(first_transistor_output_select, status_vec, running_flag);
    next_relay_out = sos_drive(relay_output_select, status_vec, running_flag);
    next_second_out = sos_drive(second_transistor_output_select, status_vec, running_flag);
  end

  // registered terminal outputs
  always @(posedge clock) begin
    if (rst) begin
      first_transistor_out <= 1'b0;
      relay_out <= 1'b0;
      second_transistor_out <= 1'b0;
    end else begin
      first_transistor_out <= next_first_out;
      relay_out <= next_relay_out;
      second_transistor_out <= next_second_out;
    end
  end

endmodule // sos_status_output_selector

// *** verif/sos_chk_sva.sv ***
// port checker for the status output selector
// assumes it is bound onto sos_status_output_selector
`timescale 1ns/1ps
module sos_chk (
  input wire clock,
  input wire rst,
  input wire [4:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire [1:0] avs_response,
  input wire running_flag,
  input wire fault_flag,
  input wire safety_stop_flag,
  input wire first_transistor_out,
  input wire relay_out,
  input wire second_transistor_out
);
  // ****************************************
  // bus and reset properties
  // ****************************************
  wire req = avs_read | avs_write;
  wire mapped = avs_address[1:0] == 2'h0 && avs_address <= 5'h10;
  property p_one_wait; @(posedge clock) disable iff (rst) !avs_waitrequest |=> avs_waitrequest; endproperty
  a_one_wait: assert property (p_one_wait) else $error("waitrequest low twice");
  property p_answer; @(posedge clock) disable iff (rst) req && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_answer: assert property (p_answer) else $error("no answer after one cycle");
  property p_unmapped; @(posedge clock) disable iff (rst)
    avs_read && avs_waitrequest && !mapped |=> avs_response == 2'h2; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  property p_mapped; @(posedge clock) disable iff (rst)
    req && avs_waitrequest && mapped |=> avs_response == 2'h0; endproperty
  a_mapped: assert property (p_mapped) else $error("mapped access refused");
  property p_upper; @(posedge clock) disable iff (rst)
    avs_read && avs_waitrequest && mapped && avs_address < 5'h0C |=> avs_readdata[31:16] == 16'h0000; endproperty
  a_upper: assert property (p_upper) else $error("code upper half not zero");
  property p_first_rst; @(posedge clock) $fell(rst) ##1 !rst |-> first_transistor_out == $past(running_flag); endproperty
  a_first_rst: assert property (p_first_rst) else $error("first terminal not running");
  property p_relay_rst; @(posedge clock) $fell(rst) ##1 !rst |-> relay_out == $past(fault_flag); endproperty
  a_relay_rst: assert property (p_relay_rst) else $error("relay not fault output");
  property p_second_rst; @(posedge clock) $fell(rst) ##1 !rst |-> second_transistor_out == $past(safety_stop_flag);
  endproperty
  a_second_rst: assert property (p_second_rst) else $error("second terminal not safety stop");
  c_unmapped: cover property (@(posedge clock) avs_response == 2'h2);
  c_write: cover property (@(posedge clock) avs_write && !avs_waitrequest);
  c_relay: cover property (@(posedge clock) $rose(relay_out));
endmodule // sos_chk
bind sos_status_output_selector sos_chk sos_chk_i (.clock(clock), .rst(rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .avs_response(avs_response), .running_flag(running_flag), .fault_flag(fault_flag),
  .safety_stop_flag(safety_stop_flag), .first_transistor_out(first_transistor_out), .relay_out(relay_out),
  .second_transistor_out(second_transistor_out));

// *** verif/sos_load.sv ***
// load model: indicator lamps on the three terminals
// assumes terminal high means conducting
`timescale 1ns/1ps
module sos_load (
  input wire clock,
  input wire first_on,
  input wire relay_on,
  input wire second_on,
  output logic [2:0] lamp
);
  // lamps follow the terminals one cycle later
  always @(posedge clock) begin
    lamp <= {second_on, relay_on, first_on};
  end
endmodule // sos_load

// *** verif/status_output_selector_test.sv ***
// self-checking bench for the status output selector
// assumes sos_consts.vh on the include path
`timescale 1ns/1ps
`include "sos_consts.vh"
module status_output_selector_test;
  logic clock = 0;
  logic rst = 1;
  logic [4:0] avs_address = 0;
  logic avs_read = 0;
  logic avs_write = 0;
  logic [31:0] avs_writedata = 0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [27:0] flags = 0;
  wire [31:0] avs_readdata;
  wire avs_waitrequest;
  wire [1:0] avs_response;
  wire first_transistor_out;
  wire relay_out;
  wire second_transistor_out;
  wire [2:0] lamp;
  int miscompares = 0;
  int n_compared = 0;
  int cyc = 0;
  integer seed = 19;
  logic [33:0] expq[$];
  logic [33:0] e;
  logic [15:0] cur[3];
  logic [31:0] v;
  logic [15:0] c;
  logic lat = 0;
  // ****************************************
  // base codes; tab[k] follows flag bit k below 14, the latch at 14, flag bit k+1 above 14
  // ****************************************
  int tab[27] = '{0, 1, 3, 4, 7, 8, 11, 12, 13, 14, 15, 16, 25, 26, 46, 47, 64, 70, 80, 81, 90, 91, 93, 95, 96, 98, 99};
  function automatic logic legal(input logic [15:0] k, input int t);
    int b;
    b = k >= `SOS_NEG_OFFSET ? k - `SOS_NEG_OFFSET : k;
    legal = 0;
    if (k == `SOS_NO_FUNC) return t != 2;
    if (k >= `SOS_NEG_LIMIT || (t == 1 && b == 93)) return 0;
    foreach (tab[i]) if (tab[i] == b) legal = 1;
  endfunction
  function automatic logic term(input logic [15:0] k);
    int b;
    b = k >= `SOS_NEG_OFFSET ? k - `SOS_NEG_OFFSET : k;
    term = 0;
    if (k == `SOS_NO_FUNC) return 0;
    foreach (tab[i]) if (tab[i] == b) term = (b == 46 ? lat : flags[i > 14 ? i + 1 : i]) ^ (k >= `SOS_NEG_OFFSET);
  endfunction
  sos_status_output_selector sos_status_output_selector_i (.clock(clock), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
    .running_flag(flags[0]), .frequency_reached_flag(flags[1]), .stall_active_flag(flags[2]),
    .freq_threshold_flag(flags[3]), .braking_duty_prealarm(flags[4]), .thermal_prealarm(flags[5]),
    .drive_ready_flag(flags[6]), .current_detect_flag(flags[7]), .low_power_detect(flags[8]),
    .loop_feedback_low(flags[9]), .loop_feedback_high(flags[10]), .loop_forward_flag(flags[11]),
    .fan_fault_flag(flags[12]), .heatsink_hot_prealarm(flags[13]), .power_loss_decel_flag(flags[14]),
    .power_loss_release(flags[15]), .loop_active_flag(flags[16]), .retry_active_flag(flags[17]),
    .loop_sleep_flag(flags[18]), .safety_stop_flag(flags[19]), .safety_ok_flag(flags[20]),
    .life_alarm_flag(flags[21]), .power_off_fault_flag(flags[22]), .current_avg_pulse(flags[23]),
    .maint_timer_flag(flags[24]), .remote_out_flag(flags[25]), .minor_alarm_flag(flags[26]), .fault_flag(flags[27]),
    .first_transistor_out(first_transistor_out), .relay_out(relay_out), .second_transistor_out(second_transistor_out));
  sos_load sos_load_i (.clock(clock), .first_on(first_transistor_out), .relay_on(relay_out),
    .second_on(second_transistor_out), .lamp(lamp));
  // ****************************************
  // clock, timeout, bus tasks and checks
  // ****************************************
  initial begin
    forever #5 clock = ~clock;
  end
  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 6000) begin
      miscompares++;
      results;
    end
  end
  task automatic cmp(input string n, input logic [33:0] x, input logic [33:0] s);
    n_compared++;
    if (s !== x) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, x, s);
    end
  endtask
  // request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clock);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0) @(posedge clock);
    avs_write <= 0;
    avs_read <= 0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [1:0] r, input logic [31:0] d);
    expq.push_back({r, d});
    bus(0, a, 0);
  endtask
  task automatic wr(input int t, input logic [15:0] k, input logic [3:0] be);
    avs_byteenable <= be;
    if (legal(k, t) && be[1:0] == 2'h3) cur[t] = k;
    bus(1, 5'(4 * t), {16'h0000, k});
  endtask
  // each completed read is matched with the oldest note
  always @(posedge clock) begin
    if (avs_read && !avs_waitrequest) begin
      e = expq.pop_front();
      cmp("read", e, {avs_response, e[33:32] == 2'h2 ? e[31:0] : avs_readdata});
    end
  end
  initial begin
    repeat (16) @(posedge clock);
    rst <= 0;
    cur = '{`SOS_RST_FIRST, `SOS_RST_RELAY, `SOS_RST_SECOND};
    for (int t = 0; t < 3; t++) rd(5'(4 * t), 0, cur[t]);
    rd(5'h14, 2'h2, 0);
    wr(1, 16'h0065, 4'hC);
    rd(5'h04, 0, cur[1]);
    for (int i = 0; i < 62; i++) begin
      v = $random(seed);
      flags <= v[27:0];
      lat = v[14] | (lat & !v[15]);
      c = i < 54 ? 16'(tab[i / 2] + (i % 2) * 100) : i == 54 ? `SOS_NO_FUNC : i == 55 ? `SOS_NEG_LIMIT : v[31:16];
      for (int t = 0; t < 3; t++) wr(t, c, 4'hF);
      for (int t = 0; t < 3; t++) rd(5'(4 * t), 0, cur[t]);
      rd(5'h10, 0, {term(cur[2]), term(cur[1]), term(cur[0])});
      cmp("lamp", {term(cur[2]), term(cur[1]), term(cur[0])}, lamp);
    end
    results;
  end
endmodule // status_output_selector_test
